// *** hdl/lfs_pkg.sv ***
// constants, types and register map of the backlight fault sequencer
// assumes a 25 MHz system clock and a power-on reset
package lfs_pkg;

  localparam int NUM_CH = 4;
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  // times as printed
  localparam int SOFT_START_MS = 65;
  localparam int BOOST_START_MS = 50;
  localparam int RECOVERY_MS = 100;
  localparam int BOOST_OV_MS = 560;
  localparam int EN_LONG_US = 50;

  localparam int TIMER_W = 24;
  localparam logic [TIMER_W-1:0] SOFT_START_CYC = TIMER_W'(SOFT_START_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] BOOST_START_CYC = TIMER_W'(BOOST_START_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] RECOVERY_CYC = TIMER_W'(RECOVERY_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] BOOST_OV_CYC = TIMER_W'(BOOST_OV_MS * CYC_PER_MS);
  localparam int EN_CNT_W = 11;
  localparam logic [EN_CNT_W-1:0] EN_LONG_CYC = EN_CNT_W'(EN_LONG_US * CYC_PER_US);

  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CAUSE = 4'h8;
  localparam logic [NUM_CH-1:0] CTRL_MASK_RST = 4'hf;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FAULT_BIT = 3;
  localparam int ST_LEDDIS_LSB = 4;
  localparam int ST_GROUND_LSB = 8;
  localparam int ST_UV_BIT = 12;
  localparam int CAUSE_W = 5;

  typedef enum {
    ST_POWERON, ST_STANDBY, ST_SOFTSTART, ST_BOOSTSTART, ST_NORMAL, ST_RECOVERY
  } lfs_state_t;

  // supply, boost and thermal comparator flags
  typedef struct packed {
    logic inputOvervoltageFault;
    logic inputBelowFalling;
    logic inputAboveRising;
    logic switchNodeOvervoltageFault;
    logic thermalShutdownFault;
    logic boostOutputOvervoltageFault;
  } lfs_flags_t;

  // per-channel comparator flags
  typedef struct packed {
    logic belowLow;
    logic aboveMid;
    logic aboveHigh;
    logic grounded;
  } lfs_chan_t;

  typedef lfs_chan_t [NUM_CH-1:0] lfs_chan_vec_t;

endpackage : lfs_pkg

// *** hdl/lfs_sequencer.sv ***
// state machine, timers and fault pin of the backlight driver
// assumes asynchronous comparator and host pins, one 25 MHz clock
//
// What this block does
// - non-LED fault: recovery, boost and sinks off, pin low
// - restart soft start after 100 ms if enabled
// - release fault pin on reaching normal cleanly
// - supply, switch-node, thermal faults watched while running
// - undervoltage fault uses falling/rising hysteresis
// - boost overvoltage declared after 560 ms, normal only
// - thermal fault holds recovery until flag releases
// - open string at max boost disables channel
// - short string with one in window disables channel
// - short enable low pulse releases LED fault pin, channel stays disabled
// - LED faults never cause recovery
// - power-on enters standby above undervoltage rising level
// - enable high in standby starts soft start
// - enable low over 50 us returns standby
// - soft start lasts 65 ms then boost start
// - boost start enables converter, reduced current limit
// - after 50 ms grounded channels excluded, normal
// - sinks conduct only while PWM high
// - LED and boost overvoltage checks only in normal
`timescale 1ns/1ns
module lfs_sequencer #(
  parameter logic [lfs_pkg::TIMER_W-1:0] SOFT_START_CYC = lfs_pkg::SOFT_START_CYC,
  parameter logic [lfs_pkg::TIMER_W-1:0] BOOST_START_CYC = lfs_pkg::BOOST_START_CYC,
  parameter logic [lfs_pkg::TIMER_W-1:0] RECOVERY_CYC = lfs_pkg::RECOVERY_CYC,
  parameter logic [lfs_pkg::TIMER_W-1:0] BOOST_OV_CYC = lfs_pkg::BOOST_OV_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host pins
  input wire logic enableIoSupplyPin,
  input wire logic brightnessPwm,
  output logic faultPinOut,
  output logic faultPinOe,
  // analog comparators
  input wire lfs_pkg::lfs_flags_t flagsIn,
  input wire lfs_pkg::lfs_chan_vec_t chanIn,
  input wire logic adaptiveAtMax,
  // power stage controls
  output logic regulatorWake,
  output logic boostEnable,
  output logic reducedCurrentLimit,
  output logic [lfs_pkg::NUM_CH-1:0] sinkChannelOutput,
  output logic [lfs_pkg::NUM_CH-1:0] loopInclude,
  // register port
  input wire logic [lfs_pkg::ADDR_W-1:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  output logic [31:0] busRdData
);
  import lfs_pkg::*;

  localparam int SYNC_W = $bits(lfs_flags_t) + $bits(lfs_chan_vec_t) + 3;

  function automatic logic [2:0] stateCode(input lfs_state_t s);
    case (s)
      ST_POWERON: stateCode = 3'h0;
      ST_STANDBY: stateCode = 3'h1;
      ST_SOFTSTART: stateCode = 3'h2;
      ST_BOOSTSTART: stateCode = 3'h3;
      ST_NORMAL: stateCode = 3'h4;
      ST_RECOVERY: stateCode = 3'h5;
      default: stateCode = 3'h7;
    endcase
  endfunction : stateCode

  function automatic logic isRunning(input lfs_state_t s);
    isRunning = (s == ST_SOFTSTART) || (s == ST_BOOSTSTART) || (s == ST_NORMAL);
  endfunction : isRunning

  // two-flop synchronisers for every pin and comparator
  logic [SYNC_W-1:0] syncMeta_q;
  logic [SYNC_W-1:0] syncOut_q;
  lfs_flags_t flagS;
  lfs_chan_vec_t chanS;
  logic enS;
  logic pwmS;
  logic adaptS;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncMeta_q <= '0;
      syncOut_q <= '0;
    end
    else
    begin
      syncMeta_q <= {flagsIn, chanIn, enableIoSupplyPin, brightnessPwm, adaptiveAtMax};
      syncOut_q <= syncMeta_q;
    end
  end

  assign {flagS, chanS, enS, pwmS, adaptS} = syncOut_q;

  // state and registers
  lfs_state_t state_q;
  lfs_state_t state_d;
  logic [TIMER_W-1:0] timer_q;
  logic [TIMER_W-1:0] bstOvCnt_q;
  logic [EN_CNT_W-1:0] enLowCnt_q;
  logic enPrev_q;
  logic uvFault_q;
  logic faultLow_q;
  logic [NUM_CH-1:0] grounded_q;
  logic [NUM_CH-1:0] grounded_d;
  logic [NUM_CH-1:0] ledDis_q;
  logic [NUM_CH-1:0] ledDis_d;
  logic [NUM_CH-1:0] ctrlMask_q;
  logic [CAUSE_W-1:0] cause_q;
  logic [NUM_CH-1:0] sink_q;
  logic [NUM_CH-1:0] loop_q;
  logic boost_q;
  logic reduced_q;
  logic wake_q;
  logic [31:0] rdData_q;

  // combinational fault view
  logic [NUM_CH-1:0] activeCh;
  logic [NUM_CH-1:0] activeD;
  logic [NUM_CH-1:0] stringOpenFault;
  logic [NUM_CH-1:0] stringShortFault;
  logic [NUM_CH-1:0] ledNew;
  logic inWindow;
  logic bstOvDeclared;
  logic [CAUSE_W-1:0] causeNow;
  logic nonLedFault;
  logic enLong;
  logic enRise;
  logic timerDone;

  assign activeCh = ctrlMask_q & ~grounded_q & ~ledDis_q;
  assign enLong = (enLowCnt_q == EN_LONG_CYC);
  assign enRise = enS && !enPrev_q;
  assign bstOvDeclared = (bstOvCnt_q >= BOOST_OV_CYC);
  assign causeNow = {bstOvDeclared && (state_q == ST_NORMAL),
                     flagS.thermalShutdownFault, flagS.switchNodeOvervoltageFault,
                     uvFault_q, flagS.inputOvervoltageFault};
  assign nonLedFault = isRunning(state_q) && (|causeNow);

  always_comb
  begin
    inWindow = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      inWindow = inWindow | (activeCh[i] & ~chanS[i].belowLow & ~chanS[i].aboveMid);
    end
  end

  // LED checks only in normal and never while a supply fault recovers
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : gLedChk
      assign stringOpenFault[g] = (state_q == ST_NORMAL) && adaptS
                                  && chanS[g].belowLow && activeCh[g];
      assign stringShortFault[g] = (state_q == ST_NORMAL) && inWindow
                                   && chanS[g].aboveHigh && activeCh[g];
    end
  endgenerate

  assign ledNew = (stringOpenFault | stringShortFault) & {NUM_CH{!nonLedFault}};

  // next state
  always_comb
  begin
    state_d = state_q;
    timerDone = 1'b0;
    case (state_q)
      ST_POWERON:
      begin
        if (!uvFault_q && flagS.inputAboveRising)
          state_d = ST_STANDBY;
      end
      ST_STANDBY:
      begin
        if (enS)
          state_d = ST_SOFTSTART;
      end
      ST_SOFTSTART:
      begin
        timerDone = (timer_q >= SOFT_START_CYC - 1'b1);
        if (nonLedFault)
          state_d = ST_RECOVERY;
        else if (enLong)
          state_d = ST_STANDBY;
        else if (timerDone)
          state_d = ST_BOOSTSTART;
      end
      ST_BOOSTSTART:
      begin
        timerDone = (timer_q >= BOOST_START_CYC - 1'b1);
        if (nonLedFault)
          state_d = ST_RECOVERY;
        else if (enLong)
          state_d = ST_STANDBY;
        else if (timerDone)
          state_d = ST_NORMAL;
      end
      ST_NORMAL:
      begin
        if (nonLedFault)
          state_d = ST_RECOVERY;
        else if (enLong)
          state_d = ST_STANDBY;
      end
      ST_RECOVERY:
      begin
        timerDone = (timer_q >= RECOVERY_CYC - 1'b1);
        if (enLong)
          state_d = ST_STANDBY;
        else if (timerDone && enS && !flagS.thermalShutdownFault)
          state_d = ST_SOFTSTART;
      end
      default: state_d = ST_POWERON;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_POWERON;
    else
      state_q <= state_d;
  end

  // state timer restarts on every state change, entry to recovery included
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_q <= '0;
    else if (state_d != state_q)
      timer_q <= '0;
    else if (timer_q != {TIMER_W{1'b1}})
      timer_q <= timer_q + 1'b1;
  end

  // boost overvoltage persistence, counted in normal only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bstOvCnt_q <= '0;
    else if (state_q != ST_NORMAL || !flagS.boostOutputOvervoltageFault)
      bstOvCnt_q <= '0;
    else if (!bstOvDeclared)
      bstOvCnt_q <= bstOvCnt_q + 1'b1;
  end

  // undervoltage with hysteresis: set below falling, cleared above rising
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      uvFault_q <= 1'b1;
    else if (flagS.inputBelowFalling)
      uvFault_q <= 1'b1;
    else if (flagS.inputAboveRising)
      uvFault_q <= 1'b0;
  end

  // enable low time; the host keeps clearing pulses within 2 to 20 us
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enLowCnt_q <= '0;
      enPrev_q <= 1'b0;
    end
    else
    begin
      enPrev_q <= enS;
      if (enS)
        enLowCnt_q <= '0;
      else if (!enLong)
        enLowCnt_q <= enLowCnt_q + 1'b1;
    end
  end

  // channel exclusion bookkeeping, refreshed at each new start
  always_comb
  begin
    grounded_d = grounded_q;
    ledDis_d = ledDis_q | ledNew;
    if (state_q != ST_SOFTSTART && state_d == ST_SOFTSTART)
    begin
      grounded_d = '0;
      ledDis_d = '0;
    end
    else if (state_q == ST_BOOSTSTART && state_d == ST_NORMAL)
    begin
      for (int i = 0; i < NUM_CH; i++)
        grounded_d[i] = chanS[i].grounded;
    end
  end

  assign activeD = ctrlMask_q & ~grounded_d & ~ledDis_d;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grounded_q <= '0;
      ledDis_q <= '0;
    end
    else
    begin
      grounded_q <= grounded_d;
      ledDis_q <= ledDis_d;
    end
  end

  // fault pin: a new fault wins over any release in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      faultLow_q <= 1'b0;
    else if (state_d == ST_RECOVERY)
      faultLow_q <= 1'b1;
    else if (|ledNew)
      faultLow_q <= 1'b1;
    else if (state_q != ST_NORMAL && state_d == ST_NORMAL)
      faultLow_q <= 1'b0;
    else if (state_q == ST_NORMAL && enRise)
      faultLow_q <= 1'b0;
    else if (state_d == ST_STANDBY)
      faultLow_q <= 1'b0;
  end

  // power stage outputs follow the next state so they change with it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_q <= 1'b0;
      boost_q <= 1'b0;
      reduced_q <= 1'b0;
      sink_q <= '0;
      loop_q <= '0;
    end
    else
    begin
      wake_q <= (state_d != ST_POWERON) && (state_d != ST_STANDBY);
      boost_q <= (state_d == ST_BOOSTSTART) || (state_d == ST_NORMAL);
      reduced_q <= (state_d == ST_BOOSTSTART);
      // sinks dark while enable is low, including a short clearing pulse
      sink_q <= (state_d == ST_NORMAL && pwmS && enS) ? activeD : '0;
      loop_q <= (state_d == ST_BOOSTSTART || state_d == ST_NORMAL) ? activeD : '0;
    end
  end

  // register port; cause bits clear by writing ones, a new cause wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrlMask_q <= CTRL_MASK_RST;
    else if (busWr && busAddr == REG_CTRL)
      ctrlMask_q <= busWrData[NUM_CH-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cause_q <= '0;
    else if (busWr && busAddr == REG_CAUSE)
      cause_q <= (cause_q & ~busWrData[CAUSE_W-1:0]) | (causeNow & {CAUSE_W{nonLedFault}});
    else
      cause_q <= cause_q | (causeNow & {CAUSE_W{nonLedFault}});
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData_q <= '0;
    else if (busRd)
    begin
      rdData_q <= '0;
      case (busAddr)
        REG_CTRL: rdData_q[NUM_CH-1:0] <= ctrlMask_q;
        REG_STATUS:
        begin
          rdData_q[ST_STATE_LSB +: 3] <= stateCode(state_q);
          rdData_q[ST_FAULT_BIT] <= faultLow_q;
          rdData_q[ST_LEDDIS_LSB +: NUM_CH] <= ledDis_q;
          rdData_q[ST_GROUND_LSB +: NUM_CH] <= grounded_q;
          rdData_q[ST_UV_BIT] <= uvFault_q;
        end
        REG_CAUSE: rdData_q[CAUSE_W-1:0] <= cause_q;
        default: rdData_q <= '0;
      endcase
    end
    else
      rdData_q <= '0;
  end

  assign faultPinOut = 1'b0;
  assign faultPinOe = faultLow_q;
  assign regulatorWake = wake_q;
  assign boostEnable = boost_q;
  assign reducedCurrentLimit = reduced_q;
  assign sinkChannelOutput = sink_q;
  assign loopInclude = loop_q;
  assign busRdData = rdData_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sFaultHit;
    isRunning(state_q) && nonLedFault;
  endsequence

  sequence sRecoveryOut;
    (state_q == ST_RECOVERY) && !boost_q && (sink_q == '0) && faultLow_q;
  endsequence

  AST_RECOVERY_ENTRY: assert property (sFaultHit |=> sRecoveryOut)
    else $error("fault did not force recovery with outputs off");
  AST_RECOVERY_TIME: assert property ((state_q == ST_RECOVERY && state_d == ST_SOFTSTART)
    |-> timer_q >= RECOVERY_CYC - 1'b1 && enS)
    else $error("recovery left early or with enable low");
  AST_NORMAL_RELEASE: assert property ((state_q == ST_BOOSTSTART && state_d == ST_NORMAL
    && ledNew == '0) |=> !faultPinOe)
    else $error("fault pin not released on normal entry");
  AST_SOFTSTART_TIME: assert property ((state_q == ST_SOFTSTART && state_d == ST_BOOSTSTART)
    |-> timer_q == SOFT_START_CYC - 1'b1)
    else $error("soft start length wrong");
  AST_BOOSTSTART_TIME: assert property ((state_q == ST_BOOSTSTART && state_d == ST_NORMAL)
    |-> timer_q == BOOST_START_CYC - 1'b1)
    else $error("boost start length wrong");
  AST_THERMAL_HOLD: assert property ((state_q == ST_RECOVERY && flagS.thermalShutdownFault)
    |=> state_q != ST_SOFTSTART)
    else $error("restart during thermal fault");
  AST_STANDBY_WAKE: assert property ((state_q == ST_STANDBY && enS)
    |=> state_q == ST_SOFTSTART ##1 regulatorWake)
    else $error("enable did not wake the device");
  AST_ENABLE_LONG: assert property ((state_q != ST_POWERON && state_q != ST_STANDBY
    && !nonLedFault && enLong) |=> state_q == ST_STANDBY)
    else $error("long enable low did not reach standby");
  AST_SINK_PWM: assert property ((sink_q != '0) |-> $past(pwmS) && state_q == ST_NORMAL)
    else $error("sink on without pwm high in normal");
  AST_LED_NO_RECOVERY: assert property ((state_q == ST_NORMAL && |ledNew && !nonLedFault)
    |=> state_q != ST_RECOVERY && faultLow_q && (sink_q & $past(ledNew)) == '0)
    else $error("LED fault mishandled");
  AST_BOOST_OV_DELAY: assert property ((state_q == ST_NORMAL && bstOvDeclared && !enLong)
    |=> state_q == ST_RECOVERY ##1 cause_q[CAUSE_W-1])
    else $error("boost overvoltage not acted on");

endmodule : lfs_sequencer

// *** dv/lfs_host_model.sv ***
// host model: drives enable and brightness pwm, watches the fault pin
// assumes an open-drain fault pin with a pull-up, one 25 MHz clock
`timescale 1ns/1ns
module lfs_host_model #(
  parameter int PWM_HALF = 625
) (
  // clock
  input wire logic clk,
  // pins
  input wire logic faultPinOut,
  input wire logic faultPinOe,
  output logic enablePin,
  output logic pwmPin,
  output logic faultLevel
);
  // pull-up wins while nobody pulls
  assign faultLevel = faultPinOe ? faultPinOut : 1'b1;
  initial
  begin
    enablePin = 1'b0;
    pwmPin = 1'b0;
  end
  task automatic setEnable(input logic v);
    @(posedge clk) enablePin <= v;
  endtask : setEnable
  // 625 cycles a phase is 20 kHz, the fastest allowed rate
  task automatic pwmPhase(input logic v);
    @(posedge clk) pwmPin <= v;
    repeat (PWM_HALF) @(posedge clk);
    #1;
  endtask : pwmPhase
  // caller keeps the low time within 2 to 20 us
  task automatic clearPulse(input int lowCyc);
    @(posedge clk) enablePin <= 1'b0;
    repeat (lowCyc) @(posedge clk);
    enablePin <= 1'b1;
  endtask : clearPulse
endmodule : lfs_host_model

// *** dv/tb_lfs_sequencer.sv ***
// self-checking bench of the backlight fault sequencer
// assumes shortened timers and the host model on the pins
`timescale 1ns/1ns
`define CHK(a, b) \
  begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_lfs_sequencer;
  import lfs_pkg::*;
  localparam int SS = 40;
  localparam int BS = 30;
  localparam int RC = 50;
  localparam int OV = 60;
  localparam lfs_flags_t FL_OK = 6'h08;
  lfs_flags_t faultTab [5] = '{6'h28, 6'h10, 6'h0c, 6'h0a, 6'h09};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  lfs_flags_t flagsIn;
  lfs_chan_vec_t chanIn;
  logic adaptiveAtMax;
  logic [ADDR_W-1:0] busAddr;
  logic [31:0] busWrData;
  logic busWr;
  logic busRd;
  wire logic enablePin, pwmPin, faultLevel, faultPinOut, faultPinOe;
  wire logic regulatorWake, boostEnable, reducedCurrentLimit;
  wire logic [NUM_CH-1:0] sinkChannelOutput, loopInclude;
  wire logic [31:0] busRdData;
  logic [31:0] st;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 45;
  always #20 clk = ~clk;
  lfs_sequencer #(.SOFT_START_CYC(TIMER_W'(SS)), .BOOST_START_CYC(TIMER_W'(BS)),
    .RECOVERY_CYC(TIMER_W'(RC)), .BOOST_OV_CYC(TIMER_W'(OV))) dut_u (
    .clk(clk), .rst_n(rst_n), .enableIoSupplyPin(enablePin), .brightnessPwm(pwmPin),
    .faultPinOut(faultPinOut), .faultPinOe(faultPinOe), .flagsIn(flagsIn),
    .chanIn(chanIn), .adaptiveAtMax(adaptiveAtMax), .regulatorWake(regulatorWake),
    .boostEnable(boostEnable), .reducedCurrentLimit(reducedCurrentLimit),
    .sinkChannelOutput(sinkChannelOutput), .loopInclude(loopInclude),
    .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
    .busRdData(busRdData));
  lfs_host_model host_u (.clk(clk), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe),
    .enablePin(enablePin), .pwmPin(pwmPin), .faultLevel(faultLevel));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk);
    busWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRd <= 1'b0;
    #1 st = busRdData;
  endtask : rd
  // expected pins follow from the model state
  task automatic chk(input int s, input logic f);
    rd(REG_STATUS);
    `CHK(st[ST_STATE_LSB +: 3], 3'(s))
    `CHK(st[ST_FAULT_BIT], f)
    `CHK(faultLevel, !f)
    `CHK(regulatorWake, (s > 1))
    `CHK(boostEnable, (s == 3 || s == 4))
    `CHK(reducedCurrentLimit, (s == 3))
    if (s != 4) `CHK(sinkChannelOutput, 4'h0)
  endtask : chk
  task automatic faultCase(input int i);
    @(posedge clk) flagsIn <= faultTab[i];
    if (i == 4)
    begin
      wt(36);
      chk(ST_NORMAL, 1'b0);
      wt(30);
    end
    wt(4);
    chk(ST_RECOVERY, 1'b1);
    rd(REG_CAUSE);
    `CHK(st[CAUSE_W-1:0], 5'(1 << i))
    if (i == 1)
    begin
      // between the two thresholds the fault must hold
      @(posedge clk) flagsIn <= '0;
      wt(4);
      rd(REG_STATUS);
      `CHK(st[ST_UV_BIT], 1'b1)
    end
    if (i != 3) @(posedge clk) flagsIn <= FL_OK;
    wr(REG_CAUSE, 32'h1f);
    rd(REG_CAUSE);
    `CHK(st[CAUSE_W-1:0], 5'h0)
    wt(50);
    if (i == 3)
    begin
      chk(ST_RECOVERY, 1'b1);
      @(posedge clk) flagsIn <= FL_OK;
      wt(6);
    end
    chk(ST_SOFTSTART, 1'b1);
    wt(75);
    chk(ST_NORMAL, 1'b0);
    `CHK(st[ST_UV_BIT], 1'b0)
    `CHK(sinkChannelOutput, 4'he)
  endtask : faultCase
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    // idle levels while reset holds the design
    flagsIn <= FL_OK;
    chanIn <= '0;
    adaptiveAtMax <= 1'b0;
    busAddr <= '0;
    busWrData <= '0;
    busWr <= 1'b0;
    busRd <= 1'b0;
    wt(3);
    rst_n <= 1'b1;
    wt(4);
    chk(ST_STANDBY, 1'b0);
    rd(REG_CTRL);
    `CHK(st, 32'h0000_000f)
    wr(REG_CTRL, ($random(seed) & 32'hffff_fff0) | 32'h7);
    rd(REG_CTRL);
    `CHK(st, 32'h0000_0007)
    wr(4'hc, $random(seed));
    rd(4'hc);
    `CHK(st, 32'h0)
    wr(REG_CTRL, 32'hf);
    @(posedge clk) chanIn[0].grounded <= 1'b1;
    host_u.setEnable(1'b1);
    wt(20);
    chk(ST_SOFTSTART, 1'b0);
    wt(25);
    chk(ST_BOOSTSTART, 1'b0);
    wt(35);
    chk(ST_NORMAL, 1'b0);
    `CHK(st[ST_GROUND_LSB +: 4], 4'h1)
    `CHK(loopInclude, 4'he)
    host_u.pwmPhase(1'b1);
    `CHK(sinkChannelOutput, 4'he)
    host_u.pwmPhase(1'b0);
    `CHK(sinkChannelOutput, 4'h0)
    @(posedge clk) adaptiveAtMax <= 1'b1;
    chanIn[1].belowLow <= 1'b1;
    wt(5);
    chk(ST_NORMAL, 1'b1);
    `CHK(st[ST_LEDDIS_LSB +: 4], 4'h2)
    `CHK(loopInclude, 4'hc)
    @(posedge clk) adaptiveAtMax <= 1'b0;
    chanIn[1].belowLow <= 1'b0;
    host_u.pwmPhase(1'b1);
    `CHK(sinkChannelOutput, 4'hc)
    fork
      host_u.clearPulse(100);
      begin
        wt(50);
        #1 `CHK(sinkChannelOutput, 4'h0)
      end
    join
    wt(5);
    chk(ST_NORMAL, 1'b0);
    `CHK(sinkChannelOutput, 4'hc)
    @(posedge clk) chanIn[2].aboveHigh <= 1'b1;
    wt(5);
    chk(ST_NORMAL, 1'b1);
    `CHK(st[ST_LEDDIS_LSB +: 4], 4'h6)
    `CHK(sinkChannelOutput, 4'h8)
    `CHK(loopInclude, 4'h8)
    @(posedge clk) chanIn[2].aboveHigh <= 1'b0;
    host_u.clearPulse(100);
    wt(5);
    for (int i = 0; i < 5; i++)
      faultCase(i);
    host_u.setEnable(1'b0);
    wt(1300);
    chk(ST_STANDBY, 1'b0);
    end_sim;
  end
  // whole run needs about 4300 cycles
  initial
  begin
    wt(20000);
    num_errors++;
    $display("FAIL t=%0t watchdog expired", $time);
    end_sim;
  end
endmodule : tb_lfs_sequencer
